// ---- rtl/amr_pkg.sv ----
// Shared constants for the operating mode configuration register block
`default_nettype none
package amr_pkg;
   // Register width and power-on value
   localparam int AMR_REG_W = 8;
   localparam logic [7:0] AMR_MODE_RST = 8'h00;
   // Field positions inside operating_mode_config
   localparam int AMR_CHOP_OFF_BIT = 7;
   localparam int AMR_CMN_BUF_BIT = 6;
   localparam int AMR_REF_SEL_BIT = 5;
   localparam int AMR_LAYOUT_BIT = 4;
   localparam int AMR_OSC_STOP_BIT = 3;
   localparam int AMR_MODE_MSB = 2;
   localparam int AMR_MODE_LSB = 0;
   // Operating mode field codes
   localparam logic [2:0] AMR_MD_PDOWN = 3'h0;
   localparam logic [2:0] AMR_MD_IDLE = 3'h1;
   localparam logic [2:0] AMR_MD_SINGLE = 3'h2;
   // Channel counts for the two layouts
   localparam logic [3:0] AMR_PSEUDO_L0 = 4'h8;
   localparam logic [3:0] AMR_PSEUDO_L1 = 4'ha;
   localparam logic [3:0] AMR_DIFF_L0 = 4'h4;
   localparam logic [3:0] AMR_DIFF_L1 = 4'h5;
   localparam logic [1:0] AMR_REFS_L0 = 2'h2;
   localparam logic [1:0] AMR_REFS_L1 = 2'h1;
   // Clock rate and oscillator start-up time
   localparam longint AMR_CLK_HZ = 64'd50_000_000;
   localparam longint AMR_OSC_START_MS = 64'd300;
   localparam longint AMR_OSC_START_CYC = (AMR_OSC_START_MS * AMR_CLK_HZ) / 64'd1000;
   localparam int AMR_OSC_CNT_W = 24;
   // Conversion sequencer states
   typedef enum logic {
      AMR_ST_IDLE,
      AMR_ST_CONV
   } amr_state_e;
endpackage
`default_nettype wire

// ---- rtl/amr_osc_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// Start-up wait for the crystal oscillator after it is restarted
module amr_osc_timer #(
   parameter int CNT_W = 24,
   parameter logic [CNT_W-1:0] CYCLES = '1
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic start_in,
   output logic busy_out
);
   // Remaining cycles of the start-up wait
   logic [CNT_W-1:0] remain;

   // Load on restart, then count down to zero
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         remain <= '0;
      end else if (start_in) begin
         remain <= CYCLES;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   // Busy while any cycle of the wait is left
   assign busy_out = (remain != '0);
endmodule
`default_nettype wire

// ---- rtl/amr_mode_ctrl.sv ----
// Contract
// RQ1: Offset swap bit clear enables chopping, default on
// RQ2: Common buffer bit buffers shared negative input
// RQ3: Reference select bit picks first/second pair
// RQ4: Ten-input layout ignores reference select bit
// RQ5: Layout bit selects eight/four or ten/five inputs
// RQ6: Stop bit halts oscillator; host waits 300 ms
// RQ7: Stop bit clear keeps oscillator running
// RQ8: Mode field decoded; power-down is reset default
// RQ9: Idle holds filter, modulator reset, clocks run
// RQ10: Single mode performs exactly one conversion
// RQ11: Eight-bit register, host reads and writes
// RQ12: Conversion done updates results, mode to idle
// RQ13: Any mode field write resets the converter
`timescale 1ns/100ps
`default_nettype none
module amr_mode_ctrl #(
   parameter logic [amr_pkg::AMR_OSC_CNT_W-1:0] OSC_START_CYCLES =
      amr_pkg::AMR_OSC_CNT_W'(amr_pkg::AMR_OSC_START_CYC)
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   // Parallel side of the serial port for this register
   input wire logic reg_wr_in,
   input wire logic [amr_pkg::AMR_REG_W-1:0] reg_wdata_in,
   output logic [amr_pkg::AMR_REG_W-1:0] reg_rdata_out,
   // Channel in use is pseudo-differential
   input wire logic pseudo_diff_in,
   // Converter reports the end of a conversion
   input wire logic conv_done_in,
   // Front end configuration
   output logic chop_en_out,
   output logic common_input_buffer_en_out,
   output logic first_reference_pair_out,
   output logic second_reference_pair_out,
   output logic channel_layout_select_out,
   output logic [3:0] pseudo_inputs_out,
   output logic [3:0] diff_inputs_out,
   output logic [1:0] reference_choices_out,
   // Oscillator control
   output logic osc_run_out,
   output logic osc_ready_out,
   // Converter control
   output logic mod_clk_run_out,
   output logic filter_reset_out,
   output logic conv_reset_out,
   output logic conv_run_out,
   output logic result_update_out
);
   import amr_pkg::*;

   // The register itself, also the read data
   logic [AMR_REG_W-1:0] mode_cfg;
   // Conversion sequencer state
   amr_state_e state;
   // Mode field and control bits as stored
   logic [2:0] md;
   logic osc_stop;
   // Oscillator run level for the next cycle
   logic next_osc_run;
   // Pulse that starts the oscillator start-up wait
   logic osc_restart;
   // Start-up wait still in progress
   logic osc_wait;
   // Conversion finishes this cycle, with no host write competing
   logic conv_finish;

   assign md = mode_cfg[AMR_MODE_MSB:AMR_MODE_LSB];
   assign osc_stop = mode_cfg[AMR_OSC_STOP_BIT];
   assign reg_rdata_out = mode_cfg;
   // A host write on the same edge wins over the hardware rewrite
   assign conv_finish = (state == AMR_ST_CONV) && conv_done_in && !reg_wr_in;

   // Register storage: host writes, hardware returns the field to idle
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         mode_cfg <= AMR_MODE_RST; // RQ8
      end else if (reg_wr_in) begin
         mode_cfg <= reg_wdata_in; // RQ11
      end else if (conv_finish) begin
         mode_cfg[AMR_MODE_MSB:AMR_MODE_LSB] <= AMR_MD_IDLE; // RQ12
      end
   end

   // Sequencer: a single-mode write starts one conversion
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state <= AMR_ST_IDLE;
      end else begin
         case (state)
            AMR_ST_IDLE: begin
               // Only the single code starts work; other codes stay put
               if (reg_wr_in && reg_wdata_in[2:0] == AMR_MD_SINGLE) begin
                  state <= AMR_ST_CONV; // RQ10
               end
            end
            AMR_ST_CONV: begin
               // A rewrite restarts or aborts the running conversion
               if (reg_wr_in) begin
                  state <= (reg_wdata_in[2:0] == AMR_MD_SINGLE) ? AMR_ST_CONV : AMR_ST_IDLE;
               end else if (conv_done_in) begin
                  state <= AMR_ST_IDLE; // RQ10
               end
            end
            default: begin
               state <= AMR_ST_IDLE;
            end
         endcase
      end
   end

   // One-cycle strobes toward the converter
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         conv_reset_out <= 1'b0;
         result_update_out <= 1'b0;
      end else begin
         // Every write carries the mode field, so every write resets
         conv_reset_out <= reg_wr_in; // RQ13
         result_update_out <= conv_finish; // RQ12
      end
   end

   // Filter runs only while a conversion is under way
   assign conv_run_out = (state == AMR_ST_CONV);
   assign filter_reset_out = (state != AMR_ST_CONV); // RQ9

   // Front end configuration, registered from the stored bits
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         chop_en_out <= 1'b1;
         common_input_buffer_en_out <= 1'b0;
         first_reference_pair_out <= 1'b1;
         second_reference_pair_out <= 1'b0;
         channel_layout_select_out <= 1'b0;
         pseudo_inputs_out <= AMR_PSEUDO_L0;
         diff_inputs_out <= AMR_DIFF_L0;
         reference_choices_out <= AMR_REFS_L0;
      end else begin
         // Set bit turns chopping off
         chop_en_out <= !mode_cfg[AMR_CHOP_OFF_BIT]; // RQ1
         // Buffering only means something on a pseudo-differential channel
         common_input_buffer_en_out <= mode_cfg[AMR_CMN_BUF_BIT] && pseudo_diff_in; // RQ2
         channel_layout_select_out <= mode_cfg[AMR_LAYOUT_BIT];
         if (mode_cfg[AMR_LAYOUT_BIT]) begin
            // Single reference layout; the select bit has no say here
            first_reference_pair_out <= 1'b1; // RQ4
            second_reference_pair_out <= 1'b0; // RQ4
            pseudo_inputs_out <= AMR_PSEUDO_L1; // RQ5
            diff_inputs_out <= AMR_DIFF_L1; // RQ5
            reference_choices_out <= AMR_REFS_L1; // RQ5
         end else begin
            first_reference_pair_out <= !mode_cfg[AMR_REF_SEL_BIT]; // RQ3
            second_reference_pair_out <= mode_cfg[AMR_REF_SEL_BIT]; // RQ3
            pseudo_inputs_out <= AMR_PSEUDO_L0; // RQ5
            diff_inputs_out <= AMR_DIFF_L0; // RQ5
            reference_choices_out <= AMR_REFS_L0; // RQ5
         end
      end
   end

   // Oscillator stops only in standby with the stop bit set
   always_comb begin
      next_osc_run = 1'b1; // RQ7
      if (md == AMR_MD_PDOWN && osc_stop) begin
         next_osc_run = 1'b0; // RQ6
      end
   end

   // Oscillator and modulator clock levels
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         osc_run_out <= 1'b1;
         mod_clk_run_out <= 1'b0;
      end else begin
         osc_run_out <= next_osc_run; // RQ6
         // Modulator clocks run in every mode except power-down
         mod_clk_run_out <= (md != AMR_MD_PDOWN); // RQ9
      end
   end

   // Restart edge of the oscillator opens the start-up wait
   assign osc_restart = next_osc_run && !osc_run_out;

   amr_osc_timer #(
      .CNT_W(AMR_OSC_CNT_W),
      .CYCLES(OSC_START_CYCLES)
   ) u_osc_timer (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .start_in(osc_restart),
      .busy_out(osc_wait)
   );

   // Ready tells the host its start-up wait is over; the host must still honour it
   assign osc_ready_out = osc_run_out && !osc_wait; // RQ6

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);

   // Chop enable follows the written bit two edges later
   property p_chop;
      reg_wr_in |-> ##2 (chop_en_out == !$past(reg_wdata_in[7], 2));
   endproperty
   a_chop: assert property (p_chop) else $error("chop enable wrong"); // RQ1

   // Common buffer needs both the bit and a pseudo-differential channel
   property p_cmn_buf;
      $rose(common_input_buffer_en_out) |->
         $past(mode_cfg[AMR_CMN_BUF_BIT]) && $past(pseudo_diff_in);
   endproperty
   a_cmn_buf: assert property (p_cmn_buf) else $error("buffer enabled wrongly"); // RQ2

   // Reference pair follows the select bit in the eight-input layout
   property p_ref_sel;
      !mode_cfg[AMR_LAYOUT_BIT] |=>
         second_reference_pair_out == $past(mode_cfg[AMR_REF_SEL_BIT])
         && first_reference_pair_out != second_reference_pair_out;
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference pair wrong"); // RQ3

   // Ten-input layout always uses the first pair
   property p_layout_ref;
      mode_cfg[AMR_LAYOUT_BIT] |=> first_reference_pair_out && !second_reference_pair_out;
   endproperty
   a_layout_ref: assert property (p_layout_ref) else $error("select not ignored"); // RQ4

   // Channel counts follow the layout bit
   property p_counts;
      ##1 (pseudo_inputs_out == ($past(mode_cfg[AMR_LAYOUT_BIT]) ? AMR_PSEUDO_L1 : AMR_PSEUDO_L0))
      && (reference_choices_out == ($past(mode_cfg[AMR_LAYOUT_BIT]) ? AMR_REFS_L1 : AMR_REFS_L0));
   endproperty
   a_counts: assert property (p_counts) else $error("channel counts wrong"); // RQ5

   // Differential input count follows the layout bit as well
   property p_diff_count;
      ##1 diff_inputs_out == ($past(mode_cfg[AMR_LAYOUT_BIT]) ? AMR_DIFF_L1 : AMR_DIFF_L0);
   endproperty
   a_diff_count: assert property (p_diff_count) else $error("differential count wrong"); // RQ5

   // Power-down with stop bit halts the oscillator next edge
   property p_osc_stop;
      (md == AMR_MD_PDOWN && osc_stop) |=> !osc_run_out && !osc_ready_out;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped"); // RQ6

   // Without the stop bit the oscillator never stops
   property p_osc_keep;
      !osc_stop |=> osc_run_out;
   endproperty
   a_osc_keep: assert property (p_osc_keep) else $error("oscillator stopped"); // RQ7

   // Reset leaves power-down in the register; must not be switched off by reset itself
   property p_rst_mode;
      @(posedge mclk_in) disable iff (1'b0)
         srst_in |=> (reg_rdata_out == AMR_MODE_RST) && !conv_run_out;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("reset value wrong"); // RQ8

   // Idle code keeps filter in reset while clocks run
   property p_idle;
      (md == AMR_MD_IDLE && !conv_run_out) [*2] |-> filter_reset_out && mod_clk_run_out;
   endproperty
   a_idle: assert property (p_idle) else $error("idle behaviour wrong"); // RQ9

   // Single-mode write starts a conversion on the next edge
   property p_single;
      reg_wr_in && reg_wdata_in[2:0] == AMR_MD_SINGLE |=> conv_run_out && !filter_reset_out;
   endproperty
   a_single: assert property (p_single) else $error("conversion not started"); // RQ10

   // Finished conversion stops; only a fresh host write may start another
   property p_one_conv;
      conv_finish |=> !conv_run_out ##1 (!conv_run_out || $past(reg_wr_in));
   endproperty
   a_one_conv: assert property (p_one_conv) else $error("conversion repeated"); // RQ10

   // Readback returns the written byte
   property p_readback;
      reg_wr_in |=> reg_rdata_out == $past(reg_wdata_in);
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch"); // RQ11

   // Completion strobes the results and returns to idle code
   property p_done;
      conv_finish |=> result_update_out && md == AMR_MD_IDLE;
   endproperty
   a_done: assert property (p_done) else $error("completion handling wrong"); // RQ12

   // A host write beats a completion on the same edge: no result strobe
   property p_wr_wins;
      conv_run_out && conv_done_in && reg_wr_in |=> !result_update_out && conv_reset_out;
   endproperty
   a_wr_wins: assert property (p_wr_wins) else $error("completion beat the write"); // RQ13

   // Every write resets the converter on the next edge
   property p_wr_reset;
      reg_wr_in |=> conv_reset_out;
   endproperty
   a_wr_reset: assert property (p_wr_reset) else $error("write did not reset"); // RQ13

   // Scenarios worth seeing
   c_single_done: cover property (reg_wr_in ##1 conv_run_out [*3] ##1 result_update_out);
   c_osc_restart: cover property (!osc_run_out ##1 osc_run_out && !osc_ready_out);
   c_layout_ten: cover property (channel_layout_select_out && mode_cfg[AMR_REF_SEL_BIT]);
   c_abort: cover property (conv_run_out && reg_wr_in && reg_wdata_in[2:0] == AMR_MD_IDLE);
   c_write_wins: cover property (conv_run_out && conv_done_in && reg_wr_in);
endmodule
`default_nettype wire

// ---- tb/amr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Host side of the register port: one strobe per byte, launched off the falling edge
module amr_host_model (
   input wire logic mclk_in,
   input wire logic osc_ready_in,
   output logic reg_wr_out,
   output logic [amr_pkg::AMR_REG_W-1:0] reg_wdata_out
);
   import amr_pkg::*;
   // Idle bus at time zero
   initial begin
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   // One write: strobe and byte held across exactly one rising edge
   task automatic write_reg(input logic [AMR_REG_W-1:0] b);
      @(negedge mclk_in);
      reg_wr_out = 1'b1;
      reg_wdata_out = b;
      @(negedge mclk_in);
      reg_wr_out = 1'b0;
      // Released data lines do not keep the byte, so the block cannot lean on it
      reg_wdata_out = ~b;
   endtask
   // Host allows the start-up time before relying on the oscillator; bounded wait
   task automatic wait_ready(input int limit, output int n);
      n = 0;
      while (osc_ready_in !== 1'b1 && n < limit) begin
         @(negedge mclk_in);
         n++;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/adc_mode_register_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_mode_register_control_test;
   import amr_pkg::*;
   // Short start-up count so the oscillator wait fits the run
   localparam int OSC_CYC = 16;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic pseudo_diff_in = 1'b0;
   logic conv_done_in = 1'b0;
   logic reg_wr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out;
   logic chop_en_out, common_input_buffer_en_out, first_reference_pair_out;
   logic second_reference_pair_out, channel_layout_select_out;
   logic [3:0] pseudo_inputs_out, diff_inputs_out;
   logic [1:0] reference_choices_out;
   logic osc_run_out, osc_ready_out, mod_clk_run_out, filter_reset_out;
   logic conv_reset_out, conv_run_out, result_update_out;
   int error_cnt = 0;
   int total_checks = 0;
   int n;
   // Configuration bytes, all in idle mode so no conversion is started
   logic [7:0] cfg_tab [5] = '{8'h81, 8'h41, 8'h21, 8'h31, 8'h79};

   always #10 mclk_in = ~mclk_in;

   amr_host_model host (
      .mclk_in(mclk_in),
      .osc_ready_in(osc_ready_out),
      .reg_wr_out(reg_wr_in),
      .reg_wdata_out(reg_wdata_in)
   );

   amr_mode_ctrl #(.OSC_START_CYCLES(AMR_OSC_CNT_W'(OSC_CYC))) dut (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out),
      .pseudo_diff_in(pseudo_diff_in),
      .conv_done_in(conv_done_in),
      .chop_en_out(chop_en_out),
      .common_input_buffer_en_out(common_input_buffer_en_out),
      .first_reference_pair_out(first_reference_pair_out),
      .second_reference_pair_out(second_reference_pair_out),
      .channel_layout_select_out(channel_layout_select_out),
      .pseudo_inputs_out(pseudo_inputs_out),
      .diff_inputs_out(diff_inputs_out),
      .reference_choices_out(reference_choices_out),
      .osc_run_out(osc_run_out),
      .osc_ready_out(osc_ready_out),
      .mod_clk_run_out(mod_clk_run_out),
      .filter_reset_out(filter_reset_out),
      .conv_reset_out(conv_reset_out),
      .conv_run_out(conv_run_out),
      .result_update_out(result_update_out)
   );

   // Single place where the run ends
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Byte compare; four-state equality so an unknown bit never matches a known one
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Front end outputs expected from a register byte and the channel kind
   task automatic check_cfg(input logic [7:0] b);
      logic sec;
      // Layout bit wins: the ten-input layout has only the first pair
      sec = b[AMR_REF_SEL_BIT] & ~b[AMR_LAYOUT_BIT];
      check({3'h0, chop_en_out, common_input_buffer_en_out, first_reference_pair_out,
             second_reference_pair_out, channel_layout_select_out},
            {3'h0, ~b[7], b[6] & pseudo_diff_in, ~sec, sec, b[4]});
      check({pseudo_inputs_out, diff_inputs_out},
            b[4] ? {AMR_PSEUDO_L1, AMR_DIFF_L1} : {AMR_PSEUDO_L0, AMR_DIFF_L0});
      check({6'h0, reference_choices_out}, {6'h0, b[4] ? AMR_REFS_L1 : AMR_REFS_L0});
   endtask

   // Hang guard: far beyond the longest legal sequence
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (5) @(negedge mclk_in);
      srst_in = 1'b0;
      check(reg_rdata_out, AMR_MODE_RST);
      check_cfg(8'h00);
      check({6'h0, mod_clk_run_out, filter_reset_out}, 8'h01);
      // Every configuration byte with both channel kinds; same mode code rewritten
      for (int p = 0; p < 2; p++) begin
         pseudo_diff_in = p[0];
         foreach (cfg_tab[i]) begin
            host.write_reg(cfg_tab[i]);
            check(reg_rdata_out, cfg_tab[i]);
            check({7'h0, conv_reset_out}, 8'h01);
            @(negedge mclk_in);
            check_cfg(cfg_tab[i]);
            check({4'h0, conv_reset_out, mod_clk_run_out, filter_reset_out, conv_run_out},
                  8'h06);
         end
      end
      // Single conversion, then a stray completion that must be ignored
      host.write_reg(8'h02);
      check({5'h0, conv_reset_out, conv_run_out, filter_reset_out}, 8'h06);
      conv_done_in = 1'b1;
      @(negedge mclk_in);
      check({5'h0, result_update_out, conv_run_out, filter_reset_out}, 8'h05);
      check(reg_rdata_out, {5'h0, AMR_MD_IDLE});
      // Completion held over one more edge, now outside any conversion
      @(negedge mclk_in);
      conv_done_in = 1'b0;
      check({6'h0, result_update_out, conv_run_out}, 8'h00);
      // Completion meeting a host write on the same edge: the write wins
      host.write_reg(8'h02);
      check({7'h0, conv_run_out}, 8'h01);
      fork
         host.write_reg(8'h01);
         begin
            @(negedge mclk_in);
            conv_done_in = 1'b1;
         end
      join
      conv_done_in = 1'b0;
      check({5'h0, conv_reset_out, result_update_out, conv_run_out}, 8'h04);
      check(reg_rdata_out, {5'h0, AMR_MD_IDLE});
      // Standby with oscillator stop, then wake and wait out the start-up time
      host.write_reg(8'h08);
      @(negedge mclk_in);
      check({6'h0, osc_run_out, osc_ready_out}, 8'h00);
      host.write_reg(8'h01);
      @(negedge mclk_in);
      check({6'h0, osc_run_out, osc_ready_out}, 8'h02);
      host.wait_ready(100, n);
      check(n[7:0], 8'(OSC_CYC));
      // Standby with the oscillator left running needs no start-up wait
      host.write_reg(8'h00);
      @(negedge mclk_in);
      check({6'h0, osc_run_out, osc_ready_out}, 8'h03);
      host.write_reg(8'h01);
      @(negedge mclk_in);
      check({6'h0, osc_run_out, osc_ready_out}, 8'h03);
      report_and_stop();
   end
endmodule
`default_nettype wire
